// [hdl/pcd_pkg.sv]
// Package with layout constants and encodings of the parameter channel decoder.
package pcd_pkg;

  // Channel word field positions.
  localparam int unsigned REQ_CODE_MSB = 15;
  localparam int unsigned REQ_CODE_LSB = 12;
  localparam int unsigned SPARE_BIT = 11;
  localparam int unsigned BASE_NUM_MSB = 10;
  localparam int unsigned SUBIDX_MSB = 15;
  localparam int unsigned SUBIDX_LSB = 8;
  localparam int unsigned PAGE_MSB = 7;

  // Subindex limit.
  localparam logic [7:0] SUBIDX_MAX = 8'hFE;

  // Page index codes and their number offsets.
  localparam logic [7:0] PAGE_0 = 8'h00;
  localparam logic [7:0] PAGE_2K = 8'h80;
  localparam logic [7:0] PAGE_6K = 8'h90;
  localparam logic [7:0] PAGE_8K = 8'h20;
  localparam logic [7:0] PAGE_10K = 8'hA0;
  localparam logic [7:0] PAGE_20K = 8'h50;
  localparam logic [7:0] PAGE_30K = 8'hF0;
  localparam logic [14:0] OFS_0 = 15'h0000;
  localparam logic [14:0] OFS_2K = 15'h07D0;
  localparam logic [14:0] OFS_6K = 15'h1770;
  localparam logic [14:0] OFS_8K = 15'h1F40;
  localparam logic [14:0] OFS_10K = 15'h2710;
  localparam logic [14:0] OFS_20K = 15'h4E20;
  localparam logic [14:0] OFS_30K = 15'h7530;

  // Request codes.
  localparam logic [3:0] REQ_NONE = 4'h0;
  localparam logic [3:0] REQ_READ = 4'h1;
  localparam logic [3:0] REQ_WRITE_W = 4'h2;
  localparam logic [3:0] REQ_WRITE_D = 4'h3;
  localparam logic [3:0] REQ_READ_FIELD = 4'h6;
  localparam logic [3:0] REQ_WRITE_FIELD_W = 4'h7;
  localparam logic [3:0] REQ_WRITE_FIELD_D = 4'h8;

  // Response codes.
  localparam logic [3:0] RSP_NONE = 4'h0;
  localparam logic [3:0] RSP_WORD = 4'h1;
  localparam logic [3:0] RSP_DWORD = 4'h2;
  localparam logic [3:0] RSP_FAIL = 4'h7;

  // Error numbers for the failure response.
  localparam logic [15:0] ERR_BAD_NUMBER = 16'h0000;
  localparam logic [15:0] ERR_BAD_SUBIDX = 16'h0003;
  localparam logic [15:0] ERR_BAD_TYPE = 16'h0005;
  localparam logic [15:0] ERR_UNSUPPORTED = 16'h006A;

  typedef enum logic [1:0] {
    PCD_IDLE,
    PCD_WAIT,
    PCD_ANSWER
  } pcd_state_e;

endpackage

// [hdl/pcd_page_decode.sv]
// Page index decoder: maps a page code to a parameter number offset.
`timescale 1ns/100ps
`default_nettype none

module pcd_page_decode
(
  // Page code in
  input wire logic [7:0] page_i,
  // Offset out
  output logic [14:0] offset_o,
  output logic valid_o
);

  always_comb
  begin
    valid_o = 1'b1;
    offset_o = pcd_pkg::OFS_0;
    case (page_i)
      pcd_pkg::PAGE_0: offset_o = pcd_pkg::OFS_0;
      pcd_pkg::PAGE_2K: offset_o = pcd_pkg::OFS_2K;
      pcd_pkg::PAGE_6K: offset_o = pcd_pkg::OFS_6K;
      pcd_pkg::PAGE_8K: offset_o = pcd_pkg::OFS_8K;
      pcd_pkg::PAGE_10K: offset_o = pcd_pkg::OFS_10K;
      pcd_pkg::PAGE_20K: offset_o = pcd_pkg::OFS_20K;
      pcd_pkg::PAGE_30K: offset_o = pcd_pkg::OFS_30K;
      default:
      begin
        valid_o = 1'b0;
      end
    endcase
  end

endmodule
`default_nettype wire

// [hdl/pcd_decoder.sv]
// Parameter channel decoder: takes one request telegram, returns one response.
//
// Added by the designer: the address map and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none

module pcd_decoder
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // Request telegram from the master
  input wire logic req_valid_i,
  input wire logic [15:0] parameter_id_word_i,
  input wire logic [15:0] parameter_index_word_i,
  input wire logic [15:0] value_high_word_i,
  input wire logic [15:0] value_low_word_i,
  // Parameter store access
  output logic store_req_o,
  output logic store_write_o,
  output logic [14:0] store_number_o,
  output logic [7:0] store_subindex_o,
  output logic store_indexed_o,
  output logic store_dword_o,
  output logic [31:0] store_wdata_o,
  input wire logic store_ack_i,
  input wire logic store_error_i,
  input wire logic [15:0] store_error_num_i,
  input wire logic store_is_dword_i,
  input wire logic [31:0] store_rdata_i,
  // Response telegram to the master
  output logic rsp_valid_o,
  output logic [15:0] rsp_id_word_o,
  output logic [15:0] rsp_index_word_o,
  output logic [15:0] rsp_value_high_o,
  output logic [15:0] rsp_value_low_o
);

  typedef struct packed {
    pcd_pkg::pcd_state_e state;
    logic [15:0] last_id;
    logic [15:0] last_ind;
    logic [31:0] last_val;
    logic have_last;
    logic req_busy;
    logic store_write;
    logic [14:0] store_number;
    logic [7:0] store_subindex;
    logic store_indexed;
    logic store_dword;
    logic [31:0] store_wdata;
    logic rsp_valid;
    logic [15:0] rsp_id;
    logic [15:0] rsp_ind;
    logic [15:0] rsp_hi;
    logic [15:0] rsp_lo;
  } pcd_state_s;

  pcd_state_s st_reg;
  pcd_state_s st_next;

  logic [3:0] req_code;
  logic [10:0] base_num;
  logic [7:0] subidx;
  logic [7:0] page;
  logic [14:0] page_ofs;
  logic page_ok;
  logic [14:0] full_num;
  logic [15:0] id_clean;
  logic is_write;
  logic is_dword;
  logic is_indexed;
  logic code_ok;
  logic repeat_req;
  logic [31:0] val_word;
  logic val_match;

  // ****************************************************************
  // Request field extraction
  // ****************************************************************
  // Bit 11 is masked out so a stray value cannot split a repeated request.
  assign id_clean = {parameter_id_word_i[15:12], 1'b0, parameter_id_word_i[10:0]};
  assign req_code = parameter_id_word_i[pcd_pkg::REQ_CODE_MSB:pcd_pkg::REQ_CODE_LSB];
  assign base_num = parameter_id_word_i[pcd_pkg::BASE_NUM_MSB:0];
  assign subidx = parameter_index_word_i[pcd_pkg::SUBIDX_MSB:pcd_pkg::SUBIDX_LSB];
  assign page = parameter_index_word_i[pcd_pkg::PAGE_MSB:0];

  pcd_page_decode u_page
  (
    .page_i(page),
    .offset_o(page_ofs),
    .valid_o(page_ok)
  );

  assign full_num = page_ofs + {4'h0, base_num};

  always_comb
  begin
    code_ok = 1'b1;
    is_write = 1'b0;
    is_dword = 1'b0;
    is_indexed = 1'b0;
    case (req_code)
      pcd_pkg::REQ_READ: is_write = 1'b0;
      pcd_pkg::REQ_WRITE_W: is_write = 1'b1;
      pcd_pkg::REQ_WRITE_D:
      begin
        is_write = 1'b1;
        is_dword = 1'b1;
      end
      pcd_pkg::REQ_READ_FIELD: is_indexed = 1'b1;
      pcd_pkg::REQ_WRITE_FIELD_W:
      begin
        is_write = 1'b1;
        is_indexed = 1'b1;
      end
      pcd_pkg::REQ_WRITE_FIELD_D:
      begin
        is_write = 1'b1;
        is_dword = 1'b1;
        is_indexed = 1'b1;
      end
      default: code_ok = 1'b0;
    endcase
  end

  // Reads ignore the value words, so filler that changes between repeats is not news.
  assign val_word = is_write ? {value_high_word_i, value_low_word_i} : 32'h0000_0000;
  assign val_match = (val_word == st_reg.last_val);

  // A repeated telegram is recognised by the ID word (bit 11 aside), the index word and, for writes only, the value words matching the last one.
  assign repeat_req = st_reg.have_last && (id_clean == st_reg.last_id) &&
    (parameter_index_word_i == st_reg.last_ind) && val_match;

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_comb
  begin
    st_next = st_reg;
    st_next.req_busy = 1'b0;
    case (st_reg.state)
      pcd_pkg::PCD_IDLE:
      begin
        if (req_valid_i && (req_code != pcd_pkg::REQ_NONE) && !repeat_req)
        begin
          st_next.last_id = id_clean;
          st_next.last_ind = parameter_index_word_i;
          st_next.last_val = val_word;
          st_next.have_last = 1'b1;
          // Rejected requests answer at once with the failure code and never reach the store.
          st_next.rsp_id = {pcd_pkg::RSP_FAIL, 1'b0, base_num};
          st_next.rsp_ind = parameter_index_word_i;
          st_next.rsp_hi = 16'h0000;
          st_next.rsp_valid = 1'b1;
          if (!code_ok)
          begin
            st_next.rsp_lo = pcd_pkg::ERR_UNSUPPORTED;
          end
          else if (!page_ok || (base_num == 11'h000))
          begin
            st_next.rsp_lo = pcd_pkg::ERR_BAD_NUMBER;
          end
          else if (subidx > pcd_pkg::SUBIDX_MAX)
          begin
            st_next.rsp_lo = pcd_pkg::ERR_BAD_SUBIDX;
          end
          else if (is_write && !is_dword && (value_high_word_i != 16'h0000))
          begin
            st_next.rsp_lo = pcd_pkg::ERR_BAD_TYPE;
          end
          else
          begin
            st_next.rsp_valid = 1'b0;
            st_next.req_busy = 1'b1;
            st_next.store_write = is_write;
            st_next.store_number = full_num;
            st_next.store_subindex = is_indexed ? subidx : 8'h00;
            st_next.store_indexed = is_indexed;
            st_next.store_dword = is_dword;
            // Read requests ignore the value words whatever the master sends.
            st_next.store_wdata = is_write ? {value_high_word_i, value_low_word_i} :
              32'h0000_0000;
            st_next.state = pcd_pkg::PCD_WAIT;
          end
        end
        else if (req_valid_i && (req_code == pcd_pkg::REQ_NONE))
        begin
          st_next.have_last = 1'b0;
          st_next.rsp_valid = 1'b1;
          st_next.rsp_id = 16'h0000;
          st_next.rsp_ind = 16'h0000;
          st_next.rsp_hi = 16'h0000;
          st_next.rsp_lo = 16'h0000;
        end
        else if (req_valid_i)
        begin
          // A repeat of an answered request gets the held response again.
          st_next.rsp_valid = 1'b1;
        end
        else
        begin
          st_next.rsp_valid = 1'b0;
        end
      end
      pcd_pkg::PCD_WAIT:
      begin
        // Telegrams arriving while the store is busy are not taken; repeats bring them back.
        st_next.req_busy = !store_ack_i;
        if (store_ack_i)
        begin
          st_next.state = pcd_pkg::PCD_ANSWER;
          st_next.rsp_ind = st_reg.last_ind;
          if (store_error_i)
          begin
            st_next.rsp_id = {pcd_pkg::RSP_FAIL, 1'b0, st_reg.last_id[10:0]};
            st_next.rsp_hi = 16'h0000;
            st_next.rsp_lo = store_error_num_i;
          end
          else if (st_reg.store_write)
          begin
            // A write echoes the value it stored.
            st_next.rsp_id = {st_reg.store_dword ? pcd_pkg::RSP_DWORD : pcd_pkg::RSP_WORD,
              1'b0, st_reg.last_id[10:0]};
            st_next.rsp_hi = st_reg.store_dword ? st_reg.store_wdata[31:16] : 16'h0000;
            st_next.rsp_lo = st_reg.store_wdata[15:0];
          end
          else if (store_is_dword_i)
          begin
            st_next.rsp_id = {pcd_pkg::RSP_DWORD, 1'b0, st_reg.last_id[10:0]};
            st_next.rsp_hi = store_rdata_i[31:16];
            st_next.rsp_lo = store_rdata_i[15:0];
          end
          else
          begin
            st_next.rsp_id = {pcd_pkg::RSP_WORD, 1'b0, st_reg.last_id[10:0]};
            st_next.rsp_hi = 16'h0000;
            st_next.rsp_lo = store_rdata_i[15:0];
          end
        end
      end
      pcd_pkg::PCD_ANSWER:
      begin
        // The whole response is presented in one beat.
        st_next.rsp_valid = 1'b1;
        st_next.state = pcd_pkg::PCD_IDLE;
      end
      default:
      begin
        st_next.state = pcd_pkg::PCD_IDLE;
      end
    endcase
  end

  // Reset forgets the held request, so the first telegram after it is always executed.
  always_ff @(posedge clk_sys_i)
  begin
    if (!reset_n_i)
    begin
      st_reg <= '0;
      st_reg.state <= pcd_pkg::PCD_IDLE;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign store_req_o = st_reg.req_busy;
  assign store_write_o = st_reg.store_write;
  assign store_number_o = st_reg.store_number;
  assign store_subindex_o = st_reg.store_subindex;
  assign store_indexed_o = st_reg.store_indexed;
  assign store_dword_o = st_reg.store_dword;
  assign store_wdata_o = st_reg.store_wdata;
  assign rsp_valid_o = st_reg.rsp_valid;
  assign rsp_id_word_o = st_reg.rsp_id;
  assign rsp_index_word_o = st_reg.rsp_ind;
  assign rsp_value_high_o = st_reg.rsp_hi;
  assign rsp_value_low_o = st_reg.rsp_lo;

endmodule
`default_nettype wire

// [tb/pcd_decoder_properties.sv]
// Port checker of the parameter channel decoder, bound to its top module.
`timescale 1ns/100ps
`default_nettype none
module pcd_decoder_chk
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // Request and store side
  input wire logic req_valid_i,
  input wire logic [15:0] parameter_id_word_i,
  input wire logic [15:0] parameter_index_word_i,
  input wire logic store_req_o,
  input wire logic store_write_o,
  input wire logic [7:0] store_subindex_o,
  input wire logic store_indexed_o,
  input wire logic store_ack_i,
  input wire logic store_error_i,
  input wire logic [15:0] store_error_num_i,
  input wire logic store_is_dword_i,
  input wire logic [31:0] store_rdata_i,
  // Response side
  input wire logic rsp_valid_o,
  input wire logic [15:0] rsp_id_word_o,
  input wire logic [15:0] rsp_value_high_o,
  input wire logic [15:0] rsp_value_low_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  logic [31:0] rdata_q;
  logic [15:0] err_q;
  wire logic [3:0] code = rsp_id_word_o[15:12];
  wire logic [3:0] req_code = parameter_id_word_i[15:12];
  wire logic [7:0] sub_in = parameter_index_word_i[15:8];
  wire logic done = store_req_o && store_ack_i;
  // ****************************************
  // The store answer is captured so the response two cycles on can be tied to it.
  // ****************************************
  always_ff @(posedge clk_sys_i)
  begin
    if (done)
    begin
      rdata_q <= store_rdata_i;
      err_q <= store_error_num_i;
    end
  end
  chk_spare_zero: assert property (rsp_valid_o |-> !rsp_id_word_o[11])
    else $error("response spare bit is set");
  chk_word_high: assert property (rsp_valid_o && code == pcd_pkg::RSP_WORD |->
    rsp_value_high_o == 16'h0000) else $error("word response high word not zero");
  chk_req_release: assert property (done |=> !store_req_o)
    else $error("store request held after ack");
  chk_req_hold: assert property (store_req_o && !store_ack_i |=>
    store_req_o && $stable(store_subindex_o)) else $error("store request changed");
  chk_word_answer: assert property (done && !store_error_i && !store_is_dword_i &&
    !store_write_o |->
    ##2 rsp_valid_o && code == pcd_pkg::RSP_WORD && rsp_value_low_o == rdata_q[15:0])
    else $error("word answer wrong");
  chk_dword_answer: assert property (done && !store_error_i && store_is_dword_i &&
    !store_write_o |-> ##2 rsp_valid_o && code == pcd_pkg::RSP_DWORD &&
    {rsp_value_high_o, rsp_value_low_o} == rdata_q) else $error("double word answer wrong");
  chk_fail_errnum: assert property (done && store_error_i |-> ##2 rsp_valid_o &&
    code == pcd_pkg::RSP_FAIL && rsp_value_low_o == err_q) else $error("failure answer wrong");
  chk_subidx_block: assert property (req_valid_i && sub_in == 8'hFF && !store_req_o |=>
    !store_req_o) else $error("subindex 255 reached the store");
  chk_subidx_pass: assert property ($rose(store_req_o) |->
    store_subindex_o == (store_indexed_o ? $past(sub_in) : 8'h00))
    else $error("subindex not passed on");
  chk_field_read: assert property ($rose(store_req_o) &&
    $past(req_code) == pcd_pkg::REQ_READ_FIELD |-> store_indexed_o)
    else $error("field read not indexed");
  cover property (done && store_is_dword_i);
  cover property (done && store_error_i);
  cover property (rsp_valid_o && code == pcd_pkg::RSP_FAIL);
endmodule
bind pcd_decoder pcd_decoder_chk u_chk (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
  .req_valid_i(req_valid_i), .parameter_id_word_i(parameter_id_word_i),
  .parameter_index_word_i(parameter_index_word_i), .store_req_o(store_req_o),
  .store_write_o(store_write_o),
  .store_subindex_o(store_subindex_o), .store_indexed_o(store_indexed_o),
  .store_ack_i(store_ack_i), .store_error_i(store_error_i),
  .store_error_num_i(store_error_num_i), .store_is_dword_i(store_is_dword_i),
  .store_rdata_i(store_rdata_i), .rsp_valid_o(rsp_valid_o), .rsp_id_word_o(rsp_id_word_o),
  .rsp_value_high_o(rsp_value_high_o), .rsp_value_low_o(rsp_value_low_o));
`default_nettype wire

// [tb/pcd_store_model.sv]
// Parameter store model answering the decoder promptly or slowly.
`timescale 1ns/100ps
`default_nettype none
module pcd_store_model
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // Access from the decoder
  input wire logic req_i,
  input wire logic [14:0] number_i,
  input wire logic [7:0] subindex_i,
  // Answer
  output logic ack_o,
  output logic error_o,
  output logic [15:0] error_num_o,
  output logic is_dword_o,
  output logic [31:0] rdata_o
);
  logic [2:0] wait_cnt = 3'h0;
  initial
  begin
    {ack_o, error_o, is_dword_o, error_num_o, rdata_o} = '0;
  end
  // Answer lines toggle outside the ack cycle so stale data never looks valid.
  always @(posedge clk_sys_i)
  begin
    ack_o <= 1'b0;
    {error_o, is_dword_o} <= ~{error_o, is_dword_o};
    error_num_o <= ~error_num_o;
    rdata_o <= ~rdata_o;
    if (!reset_n_i || !req_i || ack_o)
      wait_cnt <= 3'h0;
    else if (wait_cnt != {number_i[1], 2'b00})
      wait_cnt <= wait_cnt + 3'h1;
    else
    begin
      ack_o <= 1'b1;
      error_o <= (subindex_i == 8'hC8);
      error_num_o <= 16'h0014;
      is_dword_o <= number_i[0];
      rdata_o <= {1'b0, number_i, 8'h00, subindex_i};
    end
  end
endmodule
`default_nettype wire

// [tb/tb.sv]
// Self-checking testbench of the parameter channel decoder.
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic clk_sys_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic req_valid_i = 1'b0;
  logic [15:0] id_w = 16'h0000, idx_w = 16'h0000, hi_w = 16'h0000, lo_w = 16'h0000;
  logic s_req, s_wr, s_ix, s_dw, s_ack, s_err, s_isdw, rsp_valid, rv_q;
  logic [14:0] s_num;
  logic [7:0] s_sub;
  logic [31:0] s_wd, s_rd;
  logic [15:0] s_en, r_id, r_ix, r_hi, r_lo;
  logic [31:0] lfsr_q = 32'h0000E056;
  logic [63:0] exp_q[$];
  int failures = 0, check_count = 0;
  logic [7:0] pg [7] = '{pcd_pkg::PAGE_0, pcd_pkg::PAGE_2K, pcd_pkg::PAGE_6K,
    pcd_pkg::PAGE_8K, pcd_pkg::PAGE_10K, pcd_pkg::PAGE_20K, pcd_pkg::PAGE_30K};
  logic [14:0] ofs [7] = '{pcd_pkg::OFS_0, pcd_pkg::OFS_2K, pcd_pkg::OFS_6K,
    pcd_pkg::OFS_8K, pcd_pkg::OFS_10K, pcd_pkg::OFS_20K, pcd_pkg::OFS_30K};
  always #2 clk_sys_i = ~clk_sys_i;
  pcd_decoder dut (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .req_valid_i(req_valid_i),
    .parameter_id_word_i(id_w), .parameter_index_word_i(idx_w), .value_high_word_i(hi_w),
    .value_low_word_i(lo_w), .store_req_o(s_req), .store_write_o(s_wr),
    .store_number_o(s_num), .store_subindex_o(s_sub), .store_indexed_o(s_ix),
    .store_dword_o(s_dw), .store_wdata_o(s_wd), .store_ack_i(s_ack), .store_error_i(s_err),
    .store_error_num_i(s_en), .store_is_dword_i(s_isdw), .store_rdata_i(s_rd),
    .rsp_valid_o(rsp_valid), .rsp_id_word_o(r_id), .rsp_index_word_o(r_ix),
    .rsp_value_high_o(r_hi), .rsp_value_low_o(r_lo));
  pcd_store_model u_store (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .req_i(s_req),
    .number_i(s_num), .subindex_i(s_sub), .ack_o(s_ack), .error_o(s_err),
    .error_num_o(s_en), .is_dword_o(s_isdw), .rdata_o(s_rd));
  function automatic logic [63:0] fe(logic [10:0] b, logic [15:0] idx, logic [15:0] err);
    return {pcd_pkg::RSP_FAIL, 1'b0, b, idx, 16'h0000, err};
  endfunction
  function automatic logic [31:0] lfsr_next(logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // The store model answers with the number and the subindex it was handed.
  function automatic logic [63:0] rd_exp(logic [10:0] b, logic [14:0] o, logic [15:0] idx,
    logic [7:0] es);
    logic [14:0] n;
    logic [31:0] d;
    n = o + {4'h0, b};
    d = {1'b0, n, 8'h00, es};
    if (es == 8'hC8)
      return fe(b, idx, 16'h0014);
    if (n[0])
      return {pcd_pkg::RSP_DWORD, 1'b0, b, idx, d};
    return {pcd_pkg::RSP_WORD, 1'b0, b, idx, 16'h0000, d[15:0]};
  endfunction
  task automatic end_sim();
    $display("Counts: %0d checks, %0d mismatches", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Failure responses leave the high word open; an empty response is judged by its whole ID word.
  task automatic cmp_rsp(logic [63:0] got, logic [63:0] e);
    logic [63:0] m;
    m = (e[63:60] == pcd_pkg::RSP_FAIL) ? 64'hFFFF_FFFF_0000_FFFF :
      (e[63:60] == pcd_pkg::RSP_NONE) ? 64'hFFFF_0000_0000_0000 : '1;
    check_count++;
    if ((got & m) !== (e & m))
    begin
      failures++;
      $display("[FAIL] %0t got %h exp %h", $time, got, e);
    end
  endtask
  always @(posedge clk_sys_i)
  begin
    rv_q <= rsp_valid;
    if (rsp_valid === 1'b1 && rv_q !== 1'b1)
    begin
      if (exp_q.size() == 0)
        cmp_rsp({r_id, r_ix, r_hi, r_lo}, 64'hFFFF_FFFF_FFFF_FFFF);
      else
        cmp_rsp({r_id, r_ix, r_hi, r_lo}, exp_q.pop_front());
    end
  end
  // The request is held unchanged until its response shows up.
  task automatic send(logic [15:0] id, idx, hi, lo, logic [63:0] e);
    int n;
    n = 0;
    exp_q.push_back(e);
    @(posedge clk_sys_i);
    req_valid_i <= 1'b1;
    {id_w, idx_w, hi_w, lo_w} <= {id, idx, hi, lo};
    do
    begin
      @(posedge clk_sys_i);
      #1;
      n++;
    end
    while (rsp_valid !== 1'b1 && n < 60);
    if (rsp_valid !== 1'b1)
    begin
      failures++;
      end_sim();
    end
    @(posedge clk_sys_i);
    req_valid_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
  endtask
  task automatic rd(logic [3:0] code, int p, logic [10:0] b, logic [7:0] s);
    logic [7:0] es;
    lfsr_q = lfsr_next(lfsr_q);
    // Only field reads hand the subindex on; plain reads address the store with zero.
    es = (code == pcd_pkg::REQ_READ_FIELD) ? s : 8'h00;
    send({code, lfsr_q[5], b}, {s, pg[p]}, 16'h0000, 16'h0000,
      rd_exp(b, ofs[p], {s, pg[p]}, es));
  endtask
  initial
  begin
    repeat (2) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    for (int i = 0; i < 28; i++)
    begin
      rd(i % 2 ? pcd_pkg::REQ_READ_FIELD : pcd_pkg::REQ_READ, i % 7,
        11'(lfsr_q[15:0] % 1999 + 1), lfsr_q[23:16] == 8'hFF ? 8'hFE : lfsr_q[23:16]);
    end
    $display("Test page sweep done");
    rd(pcd_pkg::REQ_READ_FIELD, 2, 11'd1841, 8'h02);
    rd(pcd_pkg::REQ_READ_FIELD, 2, 11'd1841, 8'h02);
    rd(pcd_pkg::REQ_READ_FIELD, 0, 11'd7, 8'hC8);
    $display("Test repeat done");
    send({pcd_pkg::REQ_READ, 12'd9}, 16'h0010, 0, 0, fe(9, 16'h0010, 16'h0000));
    send({pcd_pkg::REQ_READ, 12'd0}, 16'h0000, 0, 0, fe(0, 16'h0000, 16'h0000));
    send({pcd_pkg::REQ_READ, 12'd9}, 16'hFF00, 0, 0, fe(9, 16'hFF00, 16'h0003));
    send({4'h4, 12'd9}, 16'h0000, 0, 0, fe(9, 16'h0000, 16'h006A));
    send({pcd_pkg::REQ_WRITE_W, 12'd9}, 0, 16'h0001, 16'h1234, fe(9, 0, 16'h0005));
    send({pcd_pkg::REQ_WRITE_W, 12'd9}, 0, 0, 16'h1234,
      {pcd_pkg::RSP_WORD, 12'd9, 16'h0000, 32'h0000_1234});
    send({pcd_pkg::REQ_WRITE_D, 12'd9}, 0, 16'hABCD, 16'h1234,
      {pcd_pkg::RSP_DWORD, 12'd9, 16'h0000, 32'hABCD_1234});
    send(16'h0000, 16'h0000, 0, 0, 64'h0);
    $display("Test rejects done");
    end_sim();
  end
endmodule
`default_nettype wire
